// >>> sim/tb.sv
// self-checking bench for the memory self-test result block
`timescale 1ns/1ns
`include "mst_regs.svh"

module tb;
   import mst_pkg::*;

   typedef struct
   {
      logic [31:0] exp;
      logic [31:0] msk;
      logic err;
      string what;
   } mst_note_t;

   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hF;
   logic [4:0] mem_error = 5'h00;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   mst_note_t notes[$];
   mst_note_t note;
   int n_fail = 0;
   int n_tests = 0;
   logic [9:0] sel;
   logic [4:0] err;
   logic [31:0] last;

   always #20 clk = ~clk;

   mst_top u_mst_top
   (
      .clk(clk),
      .srst(srst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .mem_error(mem_error),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .irq(irq)
   );

   // ----------------------------------------
   // comparison and verdict
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic results();
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   // ----------------------------------------
   // apb master: one idle cycle between transfers
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic [31:0] msk, input logic e,
                      input string what);
      int k;
      @(posedge clk);
      notes.push_back('{exp, msk, e, what});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
         chk("pready wait", 32'h1, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 32'h0, 1'b0, "write");
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk,
                     input string what);
      apb(1'b0, a, 32'h0, exp, msk, 1'b0, what);
   endtask : rd

   // expected outcome word: all done, fail polarity per select code
   function automatic logic [31:0] outcome(input logic [9:0] s, input logic [4:0] e);
      logic [31:0] r;
      r = 32'h0000_001F;
      for (int k = 0; k < 5; k++)
         r[16 + k] = (s[2 * k +: 2] == 2'h2) ? ~e[k] : e[k];
      return r;
   endfunction : outcome

   // ----------------------------------------
   // response watcher: oldest note against each answer
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (pready === 1'b1)
      begin
         if (notes.size() == 0)
            chk("unexpected answer", 32'h0, 32'h1);
         else
         begin
            note = notes.pop_front();
            chk(note.what, note.exp & note.msk, prdata & note.msk);
            chk("pslverr", {31'h0, note.err}, {31'h0, pslverr});
         end
      end
   end

   // watchdog: whole run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      results();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(39066));
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd(`MST_OUTCOME_ADDR, 32'h0, 32'hFFFF_FFFF, "outcome reset");
      rd(`MST_SELECT_ADDR, 32'h0, 32'hFFFF_FFFF, "select reset");
      rd(`MST_IRQ_STATUS_ADDR, 32'h0, 32'hFFFF_FFFF, "status reset");
      rd(`MST_IRQ_MASK_ADDR, 32'h0, 32'hFFFF_FFFF, "mask reset");
      apb(1'b0, 12'h040, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1, "unmapped read");
      apb(1'b1, 12'h044, 32'h1F, 32'h0, 32'h0, 1'b1, "unmapped write");
      // second run swaps 01 and 10 so every memory sees both codes
      for (int r = 0; r < 2; r++)
      begin
         err = 5'($urandom);
         if (r == 0)
            for (int k = 0; k < 5; k++)
               sel[2 * k +: 2] = 2'h1 + 2'($urandom % 2);
         else
            sel = sel ^ 10'h3FF;
         mem_error <= err;
         wr(`MST_OUTCOME_ADDR, 32'h0);
         rd(`MST_OUTCOME_ADDR, 32'h0, 32'h001F_0000, "fail cleared");
         wr(`MST_SELECT_ADDR, {22'h0, sel});
         rd(`MST_OUTCOME_ADDR, 32'h0, 32'h0000_001F, "done running");
         repeat (90) @(posedge clk);
         last = outcome(sel, err);
         rd(`MST_OUTCOME_ADDR, last, 32'hFFFF_FFFF, "outcome");
         rd(`MST_IRQ_STATUS_ADDR, 32'h1F, 32'hFFFF_FFFF, "status");
      end
      // interrupt: masked, enabled, cleared per bit
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`MST_IRQ_MASK_ADDR, 32'h10);
      repeat (3) @(posedge clk);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(`MST_IRQ_STATUS_ADDR, 32'h10);
      repeat (3) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd(`MST_IRQ_STATUS_ADDR, 32'h0F, 32'hFFFF_FFFF, "status w1c");
      wr(`MST_IRQ_STATUS_ADDR, 32'h0F);
      // a lane switched off by pstrb must not reach the mask register
      pstrb <= 4'hE;
      wr(`MST_IRQ_MASK_ADDR, 32'h0000_001F);
      pstrb <= 4'hF;
      rd(`MST_IRQ_MASK_ADDR, 32'h0, 32'hFFFF_FFFF, "strobe lanes");
      // codes 00 and 11 start nothing and keep the flags
      wr(`MST_SELECT_ADDR, 32'h0000_00F3);
      repeat (90) @(posedge clk);
      rd(`MST_OUTCOME_ADDR, last, 32'hFFFF_FFFF, "idle codes");
      rd(`MST_IRQ_STATUS_ADDR, 32'h0, 32'hFFFF_FFFF, "idle status");
      repeat (5) @(posedge clk);
      if (notes.size() != 0)
         chk("answers missing", 32'h0, 32'(notes.size()));
      results();
   end

endmodule : tb

// >>> verilog/mst_apb_slave.sv
// apb slave front end: registers the request and answers with one wait state
`timescale 1ns/1ns

module mst_apb_slave
(
   input wire logic clk,
   input wire logic srst,
   input wire mst_pkg::mst_apb_req_t req,
   input wire logic [31:0] rd_value,
   input wire logic rd_hit,
   output logic wr_strobe,
   output logic [11:0] wr_addr,
   output logic [31:0] wr_data,
   output mst_pkg::mst_apb_rsp_t rsp
);
   import mst_pkg::*;

   logic access;

   assign access = req.psel && req.penable && !rsp.pready;

   // ---------------------------------------------------------------
   // response
   // ---------------------------------------------------------------
   // pready one cycle into the access phase keeps read data registered
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rsp <= '0;
      end
      else
      begin
         rsp.pready <= access;
         rsp.pslverr <= access && !rd_hit;
         rsp.prdata <= (access && !req.pwrite && rd_hit) ? rd_value : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wr_strobe <= 1'b0;
         wr_addr <= 12'h000;
         wr_data <= 32'h0000_0000;
      end
      else
      begin
         wr_strobe <= access && req.pwrite && rd_hit;
         wr_addr <= req.paddr;
         wr_data <= req.pwdata;
      end
   end

endmodule : mst_apb_slave

// >>> verilog/mst_pkg.sv
// types shared by the memory self-test result block
package mst_pkg;

   typedef enum logic [1:0]
   {
      mst_sel_idle0 = 2'h0,
      mst_sel_memory = 2'h1,
      mst_sel_ctrl = 2'h2,
      mst_sel_idle3 = 2'h3
   } mst_sel_t;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } mst_apb_req_t;

   typedef struct packed
   {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } mst_apb_rsp_t;

   typedef struct packed
   {
      logic fail;
      logic done;
   } mst_result_t;

endpackage : mst_pkg

// >>> verilog/mst_regs.svh
// register offsets, field positions, reset values and timing counts of the memory self-test block
`ifndef MST_REGS_SVH
`define MST_REGS_SVH

// register word indices; byte address is four times the index
`define MST_OUTCOME_IDX 8'h05
`define MST_SELECT_IDX 8'h06
`define MST_IRQ_STATUS_IDX 8'h07
`define MST_IRQ_MASK_IDX 8'h08

`define MST_OUTCOME_ADDR 12'h014
`define MST_SELECT_ADDR 12'h018
`define MST_IRQ_STATUS_ADDR 12'h01C
`define MST_IRQ_MASK_ADDR 12'h020

// field positions in the outcome register
`define MST_FAIL_LSB 16
`define MST_DONE_LSB 0
`define MST_NUM_MEM 5

// reset values
`define MST_OUTCOME_RESET 32'h0000_0000
`define MST_SELECT_RESET 10'h000
`define MST_MASK_RESET 5'h00

// test select codes
`define MST_SEL_MEMORY 2'h1
`define MST_SEL_CTRL 2'h2

// duration of one self-test run, in core clock cycles
`define MST_RUN_CYCLES 8'h40

`endif

// >>> verilog/mst_runner.sv
// one memory's self-test sequencer: runs a test and reports its verdict, inverted in controller mode
`timescale 1ns/1ns
`include "mst_regs.svh"

module mst_runner
(
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   input wire mst_pkg::mst_sel_t sel,
   input wire logic bad,
   output logic busy,
   output logic finish,
   output logic verdict_fail
);
   import mst_pkg::*;

   typedef enum logic [1:0] {mst_idle, mst_run, mst_end} mst_run_state_t;

   mst_run_state_t state;
   logic [7:0] count;
   logic seen_bad;
   logic ctrl_mode;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= mst_idle;
         count <= 8'h00;
         seen_bad <= 1'b0;
         ctrl_mode <= 1'b0;
      end
      else
      begin
         unique case (state)
            mst_idle:
            begin
               // select codes 00 and 11 never launch a run
               if (start && (sel == mst_sel_memory || sel == mst_sel_ctrl))
               begin
                  state <= mst_run;
                  count <= `MST_RUN_CYCLES;
                  seen_bad <= 1'b0;
                  ctrl_mode <= (sel == mst_sel_ctrl);
               end
            end
            mst_run:
            begin
               seen_bad <= seen_bad | bad;
               count <= count - 8'h01;
               if (count == 8'h01)
               begin
                  state <= mst_end;
               end
            end
            mst_end:
            begin
               state <= mst_idle;
            end
         endcase
      end
   end

   assign busy = (state == mst_run);
   assign finish = (state == mst_end);
   // controller test: a working checker must flag the injected error
   assign verdict_fail = ctrl_mode ? ~seen_bad : seen_bad;

endmodule : mst_runner

// >>> verilog/mst_top.sv
// memory self-test result and completion reporting block with apb registers
//
// Contract
// - memory A fail on bit 20, 1 failed
// - controller test inverts the fail meaning
// - memory B fail bit 19, own select
// - memory C fail bit 18, own select
// - memory D bit 17, E bit 16
// - memory A done bit 4, 0 running
// - done bits 3 to 0 for B..E
// - fail flags clear to zero on reset
`timescale 1ns/1ns
`include "mst_regs.svh"

module mst_top
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [4:0] mem_error,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   import mst_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   // index 4 is memory A down to index 0 for memory E
   logic [4:0] fail_flag;
   logic [4:0] done_flag;
   logic [9:0] test_select;
   logic [4:0] start_pulse;
   logic [4:0] irq_status;
   logic [4:0] irq_mask;
   logic [4:0] run_busy;
   logic [4:0] run_finish;
   logic [4:0] run_fail;
   mst_apb_req_t bus_req;
   mst_apb_rsp_t bus_rsp;
   logic wr_strobe;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [31:0] rd_value;
   logic rd_hit;
   logic [4:0] next_status;

   function automatic logic [31:0] mst_lane_mask(input logic [3:0] strb);
      mst_lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : mst_lane_mask

   function automatic logic mst_is_addr(input logic [11:0] a, input logic [11:0] ref_addr);
      mst_is_addr = (a == ref_addr);
   endfunction : mst_is_addr

   assign bus_req.psel = psel;
   assign bus_req.penable = penable;
   assign bus_req.pwrite = pwrite;
   assign bus_req.paddr = paddr;
   assign bus_req.pwdata = pwdata & mst_lane_mask(pwrite ? pstrb : 4'hF);

   // ---------------------------------------------------------------
   // bus front end
   // ---------------------------------------------------------------
   mst_apb_slave u_apb
   (
      .clk(clk),
      .srst(srst),
      .req(bus_req),
      .rd_value(rd_value),
      .rd_hit(rd_hit),
      .wr_strobe(wr_strobe),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rsp(bus_rsp)
   );

   assign prdata = bus_rsp.prdata;
   assign pready = bus_rsp.pready;
   assign pslverr = bus_rsp.pslverr;

   always_comb
   begin
      rd_hit = 1'b1;
      rd_value = 32'h0000_0000;
      if (mst_is_addr(paddr, `MST_OUTCOME_ADDR))
      begin
         // unused bits 31:21 and 15:5 read as zero
         rd_value = {11'h000, fail_flag, 11'h000, done_flag};
      end
      else if (mst_is_addr(paddr, `MST_SELECT_ADDR))
      begin
         rd_value = {22'h00_0000, test_select};
      end
      else if (mst_is_addr(paddr, `MST_IRQ_STATUS_ADDR))
      begin
         rd_value = {27'h000_0000, irq_status};
      end
      else if (mst_is_addr(paddr, `MST_IRQ_MASK_ADDR))
      begin
         rd_value = {27'h000_0000, irq_mask};
      end
      else
      begin
         rd_hit = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // test select and launch
   // ---------------------------------------------------------------
   // writing a select word launches the chosen tests on idle runners; pairs are [9:8]=A .. [1:0]=E
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         test_select <= `MST_SELECT_RESET;
         start_pulse <= 5'h00;
      end
      else
      begin
         start_pulse <= 5'h00;
         if (wr_strobe && mst_is_addr(wr_addr, `MST_SELECT_ADDR))
         begin
            test_select <= wr_data[9:0];
            for (int i = 0; i < `MST_NUM_MEM; i++)
            begin
               // a runner in its end cycle drops a start but would lose its done flag
               start_pulse[i] <= !run_busy[i] && !run_finish[i];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // per-memory runners
   // ---------------------------------------------------------------
   for (genvar g = 0; g < `MST_NUM_MEM; g++)
   begin : g_run
      mst_runner u_run
      (
         .clk(clk),
         .srst(srst),
         .start(start_pulse[g]),
         .sel(mst_sel_t'(test_select[2*g+1:2*g])),
         .bad(mem_error[g]),
         .busy(run_busy[g]),
         .finish(run_finish[g]),
         .verdict_fail(run_fail[g])
      );
   end

   // ---------------------------------------------------------------
   // outcome register
   // ---------------------------------------------------------------
   // done and fail flag capture
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         fail_flag <= 5'h00;
         done_flag <= 5'h00;
      end
      else
      begin
         for (int i = 0; i < `MST_NUM_MEM; i++)
         begin
            if (start_pulse[i] && (test_select[2*i+:2] == `MST_SEL_MEMORY
                                   || test_select[2*i+:2] == `MST_SEL_CTRL))
            begin
               done_flag[i] <= 1'b0;
            end
            else if (run_finish[i])
            begin
               done_flag[i] <= 1'b1;
            end
            // finishing verdict wins over a software write in the same cycle
            if (run_finish[i])
            begin
               fail_flag[i] <= run_fail[i];
            end
            else if (wr_strobe && mst_is_addr(wr_addr, `MST_OUTCOME_ADDR))
            begin
               // software clears a stale flag before a run
               fail_flag[i] <= wr_data[`MST_FAIL_LSB + i];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   // a completion sets its sticky bit; write one to clear; set beats clear
   always_comb
   begin
      next_status = irq_status;
      if (wr_strobe && mst_is_addr(wr_addr, `MST_IRQ_STATUS_ADDR))
      begin
         next_status = next_status & ~wr_data[4:0];
      end
      next_status = next_status | run_finish;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         irq_status <= 5'h00;
         irq_mask <= `MST_MASK_RESET;
         irq <= 1'b0;
      end
      else
      begin
         irq_status <= next_status;
         if (wr_strobe && mst_is_addr(wr_addr, `MST_IRQ_MASK_ADDR))
         begin
            irq_mask <= wr_data[4:0];
         end
         irq <= |(next_status & irq_mask);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_fail_reset_zero:
      assert property (@(posedge clk) srst |=> fail_flag == 5'h00)
      else $error("fail flags not cleared by reset");

   a_memory_a_polarity:
      assert property (@(posedge clk) disable iff (srst)
         run_finish[4] && test_select[9:8] == 2'h1 |=> fail_flag[4] == $past(run_fail[4]))
      else $error("memory A verdict not captured");

   a_ctrl_inverts:
      assert property (@(posedge clk) disable iff (srst)
         run_finish[0] && g_run[0].u_run.ctrl_mode && $past(mem_error[0]) |-> !run_fail[0])
      else $error("controller test polarity wrong");

   a_memory_b_bit:
      assert property (@(posedge clk) disable iff (srst)
         ##1 pready && $past(psel && !pwrite && paddr == 12'h014)
         |-> prdata[19] == $past(fail_flag[3], 1))
      else $error("memory B fail bit misplaced");

   a_memory_c_bit:
      assert property (@(posedge clk) disable iff (srst)
         run_finish[2] |=> fail_flag[2] == $past(run_fail[2]) && done_flag[2])
      else $error("memory C result not stored");

   a_memory_de_bits:
      assert property (@(posedge clk) disable iff (srst)
         (run_finish[1] |=> done_flag[1]) and (run_finish[0] |=> done_flag[0]))
      else $error("memory D or E result missing");

   a_done_low_running:
      assert property (@(posedge clk) disable iff (srst)
         run_busy[4] |-> !done_flag[4])
      else $error("memory A done high while running");

   a_done_after_run:
      assert property (@(posedge clk) disable iff (srst)
         $fell(run_busy[3]) |-> ##[0:2] done_flag[3])
      else $error("memory B done not set after run");

   a_idle_no_start:
      assert property (@(posedge clk) disable iff (srst)
         start_pulse[0] && (test_select[1:0] == 2'h0 || test_select[1:0] == 2'h3)
         |=> !run_busy[0] ##1 $stable(done_flag[0]))
      else $error("idle select launched a test");

   a_memory_a_error:
      assert property (@(posedge clk) disable iff (srst)
         run_finish[4] && !g_run[4].u_run.ctrl_mode && $past(mem_error[4]) |-> run_fail[4])
      else $error("memory A error not reported as fail");

   a_memory_a_read:
      assert property (@(posedge clk) disable iff (srst)
         pready && $past(psel && !pwrite && paddr == `MST_OUTCOME_ADDR)
         |-> prdata[20] == $past(fail_flag[4]))
      else $error("memory A fail bit misplaced");

   a_memory_b_error:
      assert property (@(posedge clk) disable iff (srst)
         run_finish[3] && !g_run[3].u_run.ctrl_mode && $past(mem_error[3]) |-> run_fail[3])
      else $error("memory B error not reported as fail");

   a_memory_b_ctrl:
      assert property (@(posedge clk) disable iff (srst)
         run_finish[3] && g_run[3].u_run.ctrl_mode && $past(mem_error[3]) |-> !run_fail[3])
      else $error("memory B controller polarity wrong");

   a_memory_c_read:
      assert property (@(posedge clk) disable iff (srst)
         pready && $past(psel && !pwrite && paddr == `MST_OUTCOME_ADDR)
         |-> prdata[18] == $past(fail_flag[2]))
      else $error("memory C fail bit misplaced");

   a_memory_de_read:
      assert property (@(posedge clk) disable iff (srst)
         pready && $past(psel && !pwrite && paddr == `MST_OUTCOME_ADDR)
         |-> prdata[17:16] == $past(fail_flag[1:0]))
      else $error("memory D or E fail bit misplaced");

   a_memory_e_fail:
      assert property (@(posedge clk) disable iff (srst)
         run_finish[0]
         |=> fail_flag[0] == $past(run_fail[0]))
      else $error("memory E verdict not stored");

   a_done_reset:
      assert property (@(posedge clk)
         srst
         |=> done_flag == 5'h00)
      else $error("done flags not cleared by reset");

   a_done_read:
      assert property (@(posedge clk) disable iff (srst)
         pready && $past(psel && !pwrite && paddr == `MST_OUTCOME_ADDR)
         |-> prdata[4:0] == $past(done_flag))
      else $error("done bits misplaced");

   a_unused_zero:
      assert property (@(posedge clk) disable iff (srst)
         pready && $past(psel && !pwrite && paddr == `MST_OUTCOME_ADDR)
         |-> prdata[31:21] == 11'h000 && prdata[15:5] == 11'h000)
      else $error("unused outcome bits not zero");

   a_idle_fail_kept:
      assert property (@(posedge clk) disable iff (srst)
         start_pulse[1] && (test_select[3:2] == 2'h0 || test_select[3:2] == 2'h3)
         |=> !run_busy[1] && $stable(fail_flag[1]))
      else $error("idle select changed a fail flag");

endmodule : mst_top
